// *** hw/gwdt_pkg.sv ***
package gwdt_pkg;
    // Core clock and base tick rate
    localparam int unsigned CLK_HZ        = 250_000_000;
    localparam int unsigned BASE_HZ       = 8_000;
    localparam int unsigned BASE_DIV      = CLK_HZ / BASE_HZ;
    localparam int          CNT_W         = 16;
    localparam logic [15:0] RESET_COUNT   = 16'hFFFF;
    localparam int unsigned CHANNEL_INDEX = 1;
endpackage

// *** hw/gwdt_tick.sv ***
`timescale 1ns/1ps
module gwdt_tick #(
    parameter int unsigned DIV = gwdt_pkg::BASE_DIV
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Base tick
    output logic      tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         tick_q;
    logic         tick_d;

    always_comb begin
        if (cnt_q == W'(DIV - 1)) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d  = cnt_q + W'(1);
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule

// *** hw/gwdt_top.sv ***
// Behaviour
// - Counter channel one, 8 kHz base tick
// - Channel output drives timeout pin directly
// - Missed reload asserts timeout pin
// - Pin high normally, low on expiry
// - Software sets value, starts, reloads, reads status
`timescale 1ns/1ps
module gwdt_top #(
    parameter int unsigned BASE_DIV = gwdt_pkg::BASE_DIV,
    parameter int          CNT_W    = gwdt_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic             CLOCK,
    input  wire logic             RST_B,
    // Software control, same clock domain
    input  wire logic [CNT_W-1:0] TIMEOUT_VALUE,
    input  wire logic             SET_VALUE,
    input  wire logic             START,
    input  wire logic             RELOAD,
    // Status to software
    output logic                  RUNNING,
    output logic                  EXPIRED,
    output logic [CNT_W-1:0]      COUNT,
    // Timeout pin
    output logic                  WATCHDOG_TIMEOUT_N
);
    logic             tick;
    logic [CNT_W-1:0] limit_q;
    logic [CNT_W-1:0] limit_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             run_q;
    logic             run_d;
    logic             exp_q;
    logic             exp_d;
    logic             counter_one_output_q;
    logic             counter_one_output_d;
    // Rate check helper; width holds BASE_DIV itself
    localparam int    GAP_W = $clog2(BASE_DIV + 1);
    logic [GAP_W-1:0] gap_q;
    logic [GAP_W-1:0] gap_d;

    // Base clock for channel one
    gwdt_tick #(.DIV(BASE_DIV)) u_tick (
        .clk   (CLOCK),
        .rst_b (RST_B),
        .tick  (tick)
    );

    always_comb begin
        limit_d = limit_q;
        cnt_d   = cnt_q;
        run_d   = run_q;
        exp_d   = exp_q;
        if (SET_VALUE) begin
            limit_d = TIMEOUT_VALUE;
        end
        if (START || RELOAD) begin
            // Reload takes the freshly written value in the same cycle
            cnt_d = SET_VALUE ? TIMEOUT_VALUE : limit_q;
            run_d = 1'b1;
            exp_d = 1'b0;
        end else if (run_q && tick) begin
            if (cnt_q <= CNT_W'(1)) begin
                cnt_d = '0;
                run_d = 1'b0;
                exp_d = 1'b1;
            end else begin
                cnt_d = cnt_q - CNT_W'(1);
            end
        end
        counter_one_output_d = ~exp_d;
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            limit_q <= CNT_W'(gwdt_pkg::RESET_COUNT);
            cnt_q   <= '0;
            run_q   <= 1'b0;
            exp_q   <= 1'b0;
            counter_one_output_q <= 1'b1;
        end else begin
            limit_q <= limit_d;
            cnt_q   <= cnt_d;
            run_q   <= run_d;
            exp_q   <= exp_d;
            counter_one_output_q <= counter_one_output_d;
        end
    end

    // Pin is a flop of its own so it never glitches on the board
    assign WATCHDOG_TIMEOUT_N = counter_one_output_q;
    assign RUNNING = run_q;
    assign EXPIRED = exp_q;
    assign COUNT   = cnt_q;

    property p_pin_follows_channel;
        @(posedge CLOCK) disable iff (!RST_B)
        WATCHDOG_TIMEOUT_N == ~EXPIRED;
    endproperty
    a_pin_follows_channel: assert property (p_pin_follows_channel)
        else $error("timeout pin differs from channel output");

    property p_expire_on_last_tick;
        @(posedge CLOCK) disable iff (!RST_B)
        (run_q && tick && cnt_q == CNT_W'(1) && !START && !RELOAD)
            |=> !WATCHDOG_TIMEOUT_N;
    endproperty
    a_expire_on_last_tick: assert property (p_expire_on_last_tick)
        else $error("missed reload did not assert timeout");

    property p_high_while_counting;
        @(posedge CLOCK) disable iff (!RST_B)
        RUNNING |-> WATCHDOG_TIMEOUT_N;
    endproperty
    a_high_while_counting: assert property (p_high_while_counting)
        else $error("timeout pin low while counting");

    property p_reload_restores;
        @(posedge CLOCK) disable iff (!RST_B)
        (RELOAD && !SET_VALUE) |=> (WATCHDOG_TIMEOUT_N && RUNNING
            && COUNT == $past(limit_q));
    endproperty
    a_reload_restores: assert property (p_reload_restores)
        else $error("reload did not restart the count");

    property p_set_value_stored;
        @(posedge CLOCK) disable iff (!RST_B)
        (SET_VALUE && START) |=> COUNT == $past(TIMEOUT_VALUE);
    endproperty
    a_set_value_stored: assert property (p_set_value_stored)
        else $error("start did not load written value");

    property p_count_only_on_tick;
        @(posedge CLOCK) disable iff (!RST_B)
        (!tick && !START && !RELOAD) |=> $stable(COUNT);
    endproperty
    a_count_only_on_tick: assert property (p_count_only_on_tick)
        else $error("count moved without base tick");

    property p_pin_stays_low;
        @(posedge CLOCK) disable iff (!RST_B)
        (!WATCHDOG_TIMEOUT_N && !START && !RELOAD)
            |=> !WATCHDOG_TIMEOUT_N;
    endproperty
    a_pin_stays_low: assert property (p_pin_stays_low)
        else $error("timeout pin released without reload");

    property p_decrement_by_one;
        @(posedge CLOCK) disable iff (!RST_B)
        (run_q && tick && cnt_q > CNT_W'(1) && !START && !RELOAD)
            |=> COUNT == $past(cnt_q) - CNT_W'(1);
    endproperty
    a_decrement_by_one: assert property (p_decrement_by_one)
        else $error("count did not step down by one");

    // Saturates so a stalled divider stays visible to the check
    always_comb begin
        if (tick) begin
            gap_d = '0;
        end else if (gap_q == GAP_W'(BASE_DIV)) begin
            gap_d = gap_q;
        end else begin
            gap_d = gap_q + GAP_W'(1);
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            gap_q <= '0;
        end else begin
            gap_q <= gap_d;
        end
    end

    property p_tick_spacing;
        @(posedge CLOCK) disable iff (!RST_B)
        tick |-> gap_q >= GAP_W'(BASE_DIV - 1);
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("base tick came too early");

    property p_tick_not_late;
        @(posedge CLOCK) disable iff (!RST_B)
        !tick |-> gap_q < GAP_W'(BASE_DIV);
    endproperty
    a_tick_not_late: assert property (p_tick_not_late)
        else $error("base tick came too late");

    property p_start_releases_pin;
        @(posedge CLOCK) disable iff (!RST_B)
        (START || RELOAD) |=> (WATCHDOG_TIMEOUT_N && RUNNING && !EXPIRED);
    endproperty
    a_start_releases_pin: assert property (p_start_releases_pin)
        else $error("start or reload left the pin low");

    property p_expired_stopped;
        @(posedge CLOCK) disable iff (!RST_B)
        EXPIRED |-> (!RUNNING && COUNT == CNT_W'(0));
    endproperty
    a_expired_stopped: assert property (p_expired_stopped)
        else $error("channel still counting after expiry");

    property p_stopped_holds;
        @(posedge CLOCK) disable iff (!RST_B)
        (!RUNNING && !START && !RELOAD) |=> ($stable(COUNT) && !RUNNING);
    endproperty
    a_stopped_holds: assert property (p_stopped_holds)
        else $error("stopped channel moved without start");

    property p_value_kept;
        @(posedge CLOCK) disable iff (!RST_B)
        SET_VALUE |=> limit_q == $past(TIMEOUT_VALUE);
    endproperty
    a_value_kept: assert property (p_value_kept)
        else $error("timeout value was not stored");

    property p_zero_expires;
        @(posedge CLOCK) disable iff (!RST_B)
        (run_q && tick && cnt_q == CNT_W'(0) && !START && !RELOAD)
            |=> !WATCHDOG_TIMEOUT_N;
    endproperty
    a_zero_expires: assert property (p_zero_expires)
        else $error("zero count did not expire on tick");

    property p_pin_falls_on_tick;
        @(posedge CLOCK) disable iff (!RST_B)
        $fell(WATCHDOG_TIMEOUT_N) |-> ($past(run_q) && $past(tick));
    endproperty
    a_pin_falls_on_tick: assert property (p_pin_falls_on_tick)
        else $error("timeout pin fell without a base tick");
endmodule

// *** testbench/gwdt_board.sv ***
`timescale 1ns/1ps
module gwdt_board (
    // Timeout pin and supply state
    input  wire logic watchdog_timeout_n,
    input  wire logic supplies_ok,
    // Routed outputs
    output logic      irq_req,
    output logic      chk_n,
    output logic      power_ok_input
);
    assign irq_req = !watchdog_timeout_n;
    assign chk_n = watchdog_timeout_n;
    // Held inactive until supplies settle
    assign power_ok_input = supplies_ok & watchdog_timeout_n;
endmodule

// *** testbench/generic_watchdog_timer_output_test.sv ***
`timescale 1ns/1ps
module generic_watchdog_timer_output_test;
    logic        clock = 0;
    logic        rst_b = 0;
    logic [15:0] val   = 16'h0000;
    logic        set_v = 0;
    logic        start = 0;
    logic        rld   = 0;
    logic        run, exp_f, pin_n, irq, chk_n, pok;
    logic [15:0] cnt;
    int          mismatches = 0;
    int          checks_done = 0;
    always #2 clock = ~clock;
    gwdt_top #(.BASE_DIV(4)) dut (.CLOCK(clock), .RST_B(rst_b),
        .TIMEOUT_VALUE(val), .SET_VALUE(set_v), .START(start),
        .RELOAD(rld), .RUNNING(run), .EXPIRED(exp_f), .COUNT(cnt),
        .WATCHDOG_TIMEOUT_N(pin_n));
    gwdt_board board (.watchdog_timeout_n(pin_n), .supplies_ok(rst_b),
        .irq_req(irq), .chk_n(chk_n), .power_ok_input(pok));
    task results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task cyc(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task chk(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task chk1(string nm, logic e, logic g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %b got %b", nm, e, g);
        end
    endtask
    task go(logic [15:0] v, logic kick);
        @(posedge clock);
        val <= v;
        set_v <= !kick;
        start <= !kick;
        rld <= kick;
        @(posedge clock);
        {set_v, start, rld} <= 3'b000;
        #1;
    endtask
    task wait_exp(int lim);
        for (int i = 0; i < lim && exp_f !== 1'b1; i++)
            cyc(1);
    endtask
    task t_expire;
        go(16'h0003, 0);
        chk("cnt", 16'h0003, cnt);
        chk1("pin", 1'b1, pin_n);
        cyc(8);
        chk1("pin", 1'b1, pin_n);
        wait_exp(4);
        chk1("pin", 1'b0, pin_n);
        chk1("run", 1'b0, run);
        chk("cnt", 16'h0000, cnt);
        chk1("irq", 1'b1, irq);
        chk1("chk", 1'b0, chk_n);
        chk1("pok", 1'b0, pok);
        $display("expire done");
    endtask
    task t_kick;
        go(16'h0003, 1);
        chk("cnt", 16'h0003, cnt);
        chk1("pin", 1'b1, pin_n);
        chk1("irq", 1'b0, irq);
        repeat (5) begin
            cyc(4);
            go(16'h0000, 1);
            chk1("pin", 1'b1, pin_n);
        end
        $display("kick done");
    endtask
    task t_zero;
        go(16'h0000, 0);
        wait_exp(4);
        chk1("exp", 1'b1, exp_f);
        chk1("pin", 1'b0, pin_n);
        $display("zero done");
    endtask
    task t_reset;
        @(posedge clock);
        rst_b <= 0;
        cyc(2);
        chk1("pin", 1'b1, pin_n);
        chk1("pok", 1'b0, pok);
        chk("cnt", 16'h0000, cnt);
        @(posedge clock);
        rst_b <= 1;
        cyc(2);
        go(16'h0000, 1);
        chk("cnt", gwdt_pkg::RESET_COUNT, cnt);
        chk1("run", 1'b1, run);
        chk1("pok", 1'b1, pok);
        $display("reset done");
    endtask
    initial begin
        #200000;
        mismatches++;
        results();
    end
    initial begin
        cyc(12);
        chk("rst", 16'h0001, {13'h0000, exp_f, run, pin_n});
        chk1("pok", 1'b0, pok);
        @(posedge clock);
        rst_b <= 1;
        cyc(2);
        t_expire();
        t_kick();
        t_zero();
        t_reset();
        results();
    end
endmodule
